// *** inc/cmon_defines.svh ***
// Purpose: Offsets, field positions, defaults and timing counts
// Assumes: 100 MHz system clock
// Notes:   Vacuum in mbar, supply pressure in 0.1 bar steps
`ifndef CMON_DEFINES_SVH
`define CMON_DEFINES_SVH

// ****************************************************************
// Parameter indices
// ****************************************************************
`define CMON_IDX_FLAGS    16'h0092
`define CMON_IDX_H1       16'h0064
`define CMON_IDX_HY1      16'h0065
`define CMON_IDX_H2       16'h0066
`define CMON_IDX_HY2      16'h0067
`define CMON_IDX_EVAC     16'h0068
`define CMON_IDX_LEAK     16'h0069
`define CMON_IDX_ASAVE    16'h006A
`define CMON_IDX_PMIN     16'h006B
`define CMON_IDX_PMAX     16'h006C
`define CMON_IDX_FRESET   16'h006D

// ****************************************************************
// Flag bits and process data
// ****************************************************************
`define CMON_B_FREQ       0
`define CMON_B_EVAC       1
`define CMON_B_LEAK       2
`define CMON_B_CTRL       3
`define CMON_B_DYN        4
`define CMON_B_PRESS      7
`define CMON_B_PD_EVENT   6

// ****************************************************************
// Factory settings
// ****************************************************************
`define CMON_DEF_H1       10'h2EE
`define CMON_DEF_HY1      10'h096
`define CMON_DEF_H2       10'h226
`define CMON_DEF_HY2      10'h00A
`define CMON_DEF_EVAC     10'h0C8
`define CMON_DEF_LEAK     3'h3
`define CMON_DEF_ASAVE    1'h1
`define CMON_DEF_PMIN     8'h28
`define CMON_DEF_PMAX     8'h46

// ****************************************************************
// Limits and timing
// ****************************************************************
`define CMON_EVAC_MAX     10'h3E7
`define CMON_EVAC_UNIT_MS 14'hA
`define CMON_LEAK_MAX_SEL 3'h6
`define CMON_TOG_LIMIT    3'h7
`define CMON_CLK_NS       10
`define CMON_MS_NS        1000000
`define CMON_TICK_CYC     (`CMON_MS_NS / `CMON_CLK_NS)
`define CMON_FREQ_WIN_MS  3000
`define CMON_DYN_MS       1000
`define CMON_LEAK_WIN_MS  100
`define CMON_LEAK_SCALE   10

`endif

// *** inc/cmon_pkg.sv ***
// Purpose: Types shared by the condition monitor modules
// Assumes: Included defines header
// Notes:   State of each module is one packed struct
`include "cmon_defines.svh"

package cmon_pkg;

  // ****************************************************************
  // Indicator patterns
  // ****************************************************************
  typedef enum logic [1:0] {
    CMON_LED_VACUUM,
    CMON_LED_GRN_FLASH,
    CMON_LED_RED_FLASH
  } cmon_led_e;

  // ****************************************************************
  // Configuration restored by factory reset
  // ****************************************************************
  typedef struct packed {
    logic [9:0] h1;
    logic [9:0] hy1;
    logic [9:0] h2;
    logic [9:0] hy2;
    logic [9:0] evac;
    logic [2:0] leak_sel;
    logic       asave;
    logic [7:0] pmin;
    logic [7:0] pmax;
  } cmon_cfg_s;

  typedef struct packed {
    cmon_cfg_s   cfg;
    logic [7:0]  flags;
    logic        cmd;
    logic        in_cycle;
    logic        valve;
    logic        cont;
    logic        reached_h1;
    logic        evac_run;
    logic [13:0] evac_ms;
    logic [9:0]  dyn_ms;
    logic        dyn_ok;
    logic [1:0]  leak_cnt;
    logic [16:0] tick_cnt;
    logic        tick;
    logic        diag;
    cmon_led_e   led;
    logic [7:0]  pd;
    logic [15:0] rdata;
    logic        rvalid;
    logic        rerr;
    logic        wack;
    logic        werr;
  } cmon_st_s;

  typedef struct packed {
    logic [6:0][11:0] age;
    logic [2:0]       idx;
    logic [2:0]       fill;
    logic             burst;
  } cmon_tog_s;

  typedef struct packed {
    logic [9:0]  start;
    logic [6:0]  ms;
    logic        run;
    logic        excess;
  } cmon_leak_s;

endpackage

// *** hdl/cmon_toggle_window.sv ***
// Purpose: Sliding window count of valve toggles
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   Ages saturate so stale entries never alias as recent
`timescale 1ns/10ps
`include "cmon_defines.svh"
module cmon_toggle_window
  import cmon_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic toggle,
  input  wire logic clear,
  output logic      burst
);

  localparam logic [11:0] WIN = 12'(`CMON_FREQ_WIN_MS);

  cmon_tog_s s_q;
  cmon_tog_s s_d;

  // ****************************************************************
  // Seven ages: a toggle is the seventh within the window when the
  // sixth one back, in the slot after idx, is still inside it
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.burst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (tick && s_q.age[i] < WIN) begin
        s_d.age[i] = s_q.age[i] + 12'h001;
      end
    end
    if (clear) begin
      s_d.fill = 3'h0;
      s_d.idx  = 3'h0;
    end else if (toggle) begin
      if (s_q.fill == 3'h6 &&
          s_q.age[(s_q.idx == 3'h6) ? 3'h0 : s_q.idx + 3'h1] < WIN) begin
        s_d.burst = 1'b1;
      end
      if (s_q.fill != 3'h6) begin
        s_d.fill = s_q.fill + 3'h1;
      end
      s_d.age[s_q.idx] = 12'h000;
      s_d.idx = (s_q.idx == 3'h6) ? 3'h0 : s_q.idx + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign burst = s_q.burst;

endmodule // cmon_toggle_window

// *** hdl/cmon_leak_rate.sv ***
// Purpose: Vacuum drop rate check while suction is paused
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   Rate is the drop over a fixed window scaled to mbar/s
`timescale 1ns/10ps
`include "cmon_defines.svh"
module cmon_leak_rate
  import cmon_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       active,
  input  wire logic [9:0] vacuum,
  input  wire logic [7:0] limit,
  output logic            excess
);

  localparam logic [6:0]  WIN   = 7'(`CMON_LEAK_WIN_MS - 1);
  localparam logic [13:0] SCALE = 14'(`CMON_LEAK_SCALE);

  cmon_leak_s  s_q;
  cmon_leak_s  s_d;
  logic [13:0] rate;

  // ****************************************************************
  // One evaluation per window, so each pause is checked anew
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.excess = 1'b0;
    rate = '0;
    if (s_q.start > vacuum) begin
      rate = 14'(s_q.start - vacuum) * SCALE;
    end
    if (!active) begin
      s_d.run = 1'b0;
    end else if (!s_q.run) begin
      s_d.run   = 1'b1;
      s_d.start = vacuum;
      s_d.ms    = '0;
    end else if (tick) begin
      if (s_q.ms == WIN) begin
        s_d.excess = rate > {6'h00, limit};
        s_d.start  = vacuum;
        s_d.ms     = '0;
      end else begin
        s_d.ms = s_q.ms + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign excess = s_q.excess;

endmodule // cmon_leak_rate

// *** hdl/cmon_monitor.sv ***
// Purpose: Suction control and condition monitoring of an ejector
// Assumes: All inputs synchronous to clk; vacuum in mbar
// Notes:   Parameter port is the IO-Link side; flags read at 0x0092
//
// What this block does
// - Over six toggles in 3 s forces suction
// - Frequency fault: diag, green flash, bit 0
// - Any flag raises process data bit 6
// - Control-off never reached: diag, red, bit 3
// - Slow evacuation: diag, red flash, bit 1
// - Limit zero disables; limit at most 9.99 s
// - Small leak: wait for control-on, no warning
// - Leak excess resumes; second forces, diag, bit 2
// - Leak limit from seven fixed choices only
// - Leak checked in every control cycle
// - Supply pressure outside window sets bit 7
// - Dynamic vacuum in band at start: bit 4
// - Pressure warnings touch neither LED nor diag
// - Pressure checks only with pressure sensor
// - Diag output held until next cycle
// - Vacuum below threshold shows live vacuum
// - After cycle, result shown until next
// - Factory reset restores settings, nothing else
// - Monitoring active only in IO-Link mode
`timescale 1ns/10ps
`include "cmon_defines.svh"
module cmon_monitor
  import cmon_pkg::*;
#(
  parameter int TICK_CYC = `CMON_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        suction_cmd,
  input  wire logic [9:0]  vacuum,
  input  wire logic [7:0]  supply_pressure,
  input  wire logic        has_pressure_sensor,
  input  wire logic        iolink_mode,
  input  wire logic        menu_factory_reset,
  input  wire logic        param_rd,
  input  wire logic        param_wr,
  input  wire logic [15:0] param_index,
  input  wire logic [15:0] param_wdata,
  output logic [15:0]      param_rdata,
  output logic             param_rvalid,
  output logic             param_rerr,
  output logic             param_wack,
  output logic             param_werr,
  output logic             suction_valve,
  output logic             diag_output,
  output cmon_led_e        led_mode,
  output logic [7:0]       pd_in_byte,
  output logic [7:0]       condition_monitoring_flags
);

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);
  localparam logic [9:0]  DYN_LAST  = 10'(`CMON_DYN_MS - 1);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [9:0] sat_sub(input logic [9:0] a,
                                         input logic [9:0] b);
    sat_sub = (a > b) ? a - b : 10'h000;
  endfunction

  function automatic logic [7:0] leak_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    leak_limit = 8'h04;
      3'h1:    leak_limit = 8'h0B;
      3'h2:    leak_limit = 8'h19;
      3'h3:    leak_limit = 8'h32;
      3'h4:    leak_limit = 8'h64;
      3'h5:    leak_limit = 8'h96;
      default: leak_limit = 8'hFA;
    endcase
  endfunction

  function automatic cmon_cfg_s cfg_default();
    cmon_cfg_s c;
    c.h1       = `CMON_DEF_H1;
    c.hy1      = `CMON_DEF_HY1;
    c.h2       = `CMON_DEF_H2;
    c.hy2      = `CMON_DEF_HY2;
    c.evac     = `CMON_DEF_EVAC;
    c.leak_sel = `CMON_DEF_LEAK;
    c.asave    = `CMON_DEF_ASAVE;
    c.pmin     = `CMON_DEF_PMIN;
    c.pmax     = `CMON_DEF_PMAX;
    cfg_default = c;
  endfunction

  cmon_st_s   s_q;
  cmon_st_s   s_d;
  logic       toggle;
  logic       burst;
  logic       leak_active;
  logic       leak_excess;
  logic       cyc_start;
  logic       cyc_end;
  logic [7:0] set_bits;
  logic       diag_set;
  logic [9:0] h1_on;
  logic [9:0] h2_off;
  logic       wr_ok;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  cmon_toggle_window u_tog (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick   (s_q.tick),
    .toggle (toggle),
    .clear  (cyc_start),
    .burst  (burst)
  );

  cmon_leak_rate u_leak (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick   (s_q.tick),
    .active (leak_active),
    .vacuum (vacuum),
    .limit  (leak_limit(s_q.cfg.leak_sel)),
    .excess (leak_excess)
  );

  // ****************************************************************
  // Cycle framing and shared terms
  // ****************************************************************
  assign cyc_start = suction_cmd && !s_q.cmd;
  assign cyc_end   = !suction_cmd && s_q.cmd;
  assign h1_on     = sat_sub(s_q.cfg.h1, s_q.cfg.hy1);
  assign h2_off    = sat_sub(s_q.cfg.h2, s_q.cfg.hy2);
  // Leak window only runs while control has paused the valve
  assign leak_active = s_q.in_cycle && s_q.cfg.asave && !s_q.cont &&
                       !s_q.valve && s_q.reached_h1;
  assign toggle    = s_q.in_cycle && (s_d.valve != s_q.valve);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d        = s_q;
    set_bits   = 8'h00;
    diag_set   = 1'b0;
    wr_ok      = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.rerr   = 1'b0;
    s_d.wack   = 1'b0;
    s_d.werr   = 1'b0;
    s_d.cmd    = suction_cmd;

    // Millisecond time base
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == TICK_LAST) begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 17'h00001;
    end

    // Clearing first, so events of this same cycle still land
    if (cyc_start) begin
      s_d.flags      = 8'h00;
      s_d.diag       = 1'b0;
      s_d.cont       = 1'b0;
      s_d.in_cycle   = 1'b1;
      s_d.reached_h1 = 1'b0;
      s_d.evac_run   = 1'b0;
      s_d.evac_ms    = '0;
      s_d.dyn_ms     = '0;
      s_d.dyn_ok     = 1'b1;
      s_d.leak_cnt   = 2'h0;
    end else if (cyc_end) begin
      s_d.in_cycle = 1'b0;
      if (!s_q.reached_h1) begin
        set_bits[`CMON_B_CTRL] = 1'b1;
      end
    end

    // Suction valve: plain or air saving control
    if (!s_d.in_cycle) begin
      s_d.valve = 1'b0;
    end else if (!s_q.cfg.asave || s_q.cont) begin
      s_d.valve = 1'b1;
    end else if (s_q.valve && vacuum >= s_q.cfg.h1) begin
      s_d.valve = 1'b0;
    end else if (!s_q.valve && leak_excess) begin
      s_d.valve = 1'b1;
    end else if (!s_q.valve && vacuum < h1_on) begin
      s_d.valve = 1'b1;
    end

    if (s_q.in_cycle && vacuum >= s_q.cfg.h1) begin
      s_d.reached_h1 = 1'b1;
    end

    // Evacuation time from part-present to control-off
    if (s_q.in_cycle && !s_q.reached_h1) begin
      if (vacuum >= s_q.cfg.h1) begin
        s_d.evac_run = 1'b0;
      end else if (vacuum >= s_q.cfg.h2) begin
        s_d.evac_run = 1'b1;
      end
      if (s_q.evac_run && s_q.tick && s_q.evac_ms != 14'h3FFF) begin
        s_d.evac_ms = s_q.evac_ms + 14'h0001;
      end
    end
    if (s_q.cfg.evac != 10'h000 && s_q.evac_run &&
        s_q.evac_ms > 14'(s_q.cfg.evac) * `CMON_EVAC_UNIT_MS) begin
      set_bits[`CMON_B_EVAC] = 1'b1;
    end

    // Dynamic pressure after one second of unobstructed suction
    if (s_q.in_cycle && s_q.dyn_ok && s_q.tick) begin
      if (!s_q.valve) begin
        s_d.dyn_ok = 1'b0;
      end else if (s_q.dyn_ms == DYN_LAST) begin
        s_d.dyn_ok = 1'b0;
        if (has_pressure_sensor && vacuum > h2_off &&
            vacuum < s_q.cfg.h1) begin
          set_bits[`CMON_B_DYN] = 1'b1;
        end
      end else begin
        s_d.dyn_ms = s_q.dyn_ms + 10'h001;
      end
    end

    // Leakage: second excess of a cycle forces continuous suction
    if (leak_excess) begin
      if (s_q.leak_cnt != 2'h0) begin
        s_d.cont = 1'b1;
        set_bits[`CMON_B_LEAK] = 1'b1;
      end else begin
        s_d.leak_cnt = 2'h1;
      end
    end

    // Valve chatter
    if (burst && s_q.cfg.asave) begin
      s_d.cont = 1'b1;
      set_bits[`CMON_B_FREQ] = 1'b1;
    end

    // Supply pressure window
    if (has_pressure_sensor &&
        (supply_pressure < s_q.cfg.pmin ||
         supply_pressure > s_q.cfg.pmax)) begin
      set_bits[`CMON_B_PRESS] = 1'b1;
    end

    // Monitoring exists only in IO-Link mode
    if (!iolink_mode) begin
      set_bits = 8'h00;
      s_d.cont = 1'b0;
    end

    s_d.flags = s_d.flags | set_bits;
    // Pressure and dynamic bits stay out of the diag output
    diag_set = |set_bits[3:0];
    s_d.diag = s_d.diag | diag_set;
    s_d.pd = 8'h00;
    s_d.pd[`CMON_B_PD_EVENT] = |s_d.flags;

    // Indicator: green flash outranks red since it means forced suction
    if (s_d.in_cycle &&
        (vacuum < s_q.cfg.h1 || vacuum < s_q.cfg.h2)) begin
      s_d.led = CMON_LED_VACUUM;
    end else if (s_d.flags[`CMON_B_FREQ] ||
                 s_d.flags[`CMON_B_LEAK]) begin
      s_d.led = CMON_LED_GRN_FLASH;
    end else if (s_d.flags[`CMON_B_EVAC] ||
                 s_d.flags[`CMON_B_CTRL]) begin
      s_d.led = CMON_LED_RED_FLASH;
    end else begin
      s_d.led = CMON_LED_VACUUM;
    end

    // Parameter reads
    if (param_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = 16'h0000;
      if (param_index == `CMON_IDX_FLAGS) begin
        s_d.rdata = {8'h00, s_q.flags};
      end else if (param_index == `CMON_IDX_H1) begin
        s_d.rdata = {6'h00, s_q.cfg.h1};
      end else if (param_index == `CMON_IDX_HY1) begin
        s_d.rdata = {6'h00, s_q.cfg.hy1};
      end else if (param_index == `CMON_IDX_H2) begin
        s_d.rdata = {6'h00, s_q.cfg.h2};
      end else if (param_index == `CMON_IDX_HY2) begin
        s_d.rdata = {6'h00, s_q.cfg.hy2};
      end else if (param_index == `CMON_IDX_EVAC) begin
        s_d.rdata = {6'h00, s_q.cfg.evac};
      end else if (param_index == `CMON_IDX_LEAK) begin
        s_d.rdata = {13'h0000, s_q.cfg.leak_sel};
      end else if (param_index == `CMON_IDX_ASAVE) begin
        s_d.rdata = {15'h0000, s_q.cfg.asave};
      end else if (param_index == `CMON_IDX_PMIN) begin
        s_d.rdata = {8'h00, s_q.cfg.pmin};
      end else if (param_index == `CMON_IDX_PMAX) begin
        s_d.rdata = {8'h00, s_q.cfg.pmax};
      end else begin
        s_d.rerr = 1'b1;
      end
    end

    // Parameter writes; out-of-range evacuation times and leak choices are refused whole
    if (param_wr) begin
      wr_ok = 1'b1;
      if (param_index == `CMON_IDX_H1) begin
        s_d.cfg.h1 = param_wdata[9:0];
      end else if (param_index == `CMON_IDX_HY1) begin
        s_d.cfg.hy1 = param_wdata[9:0];
      end else if (param_index == `CMON_IDX_H2) begin
        s_d.cfg.h2 = param_wdata[9:0];
      end else if (param_index == `CMON_IDX_HY2) begin
        s_d.cfg.hy2 = param_wdata[9:0];
      end else if (param_index == `CMON_IDX_EVAC &&
                   param_wdata <= 16'(`CMON_EVAC_MAX)) begin
        s_d.cfg.evac = param_wdata[9:0];
      end else if (param_index == `CMON_IDX_LEAK &&
                   param_wdata <= 16'(`CMON_LEAK_MAX_SEL)) begin
        s_d.cfg.leak_sel = param_wdata[2:0];
      end else if (param_index == `CMON_IDX_ASAVE) begin
        s_d.cfg.asave = param_wdata[0];
      end else if (param_index == `CMON_IDX_PMIN) begin
        s_d.cfg.pmin = param_wdata[7:0];
      end else if (param_index == `CMON_IDX_PMAX) begin
        s_d.cfg.pmax = param_wdata[7:0];
      end else if (param_index == `CMON_IDX_FRESET) begin
        s_d.cfg = cfg_default();
      end else begin
        wr_ok = 1'b0;
      end
      s_d.wack = wr_ok;
      s_d.werr = !wr_ok;
    end

    // Menu reset touches settings only; flags and timers run on
    if (menu_factory_reset) begin
      s_d.cfg = cfg_default();
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q     <= '0;
      s_q.cfg <= cfg_default();
      s_q.led <= CMON_LED_VACUUM;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign param_rdata   = s_q.rdata;
  assign param_rvalid  = s_q.rvalid;
  assign param_rerr    = s_q.rerr;
  assign param_wack    = s_q.wack;
  assign param_werr    = s_q.werr;
  assign suction_valve = s_q.valve;
  assign diag_output   = s_q.diag;
  assign led_mode      = s_q.led;
  assign pd_in_byte    = s_q.pd;
  assign condition_monitoring_flags = s_q.flags;

endmodule // cmon_monitor

// *** verif/cmon_master_model.sv ***
// Purpose: Parameter master standing in for the IO-Link side
// Assumes: Tasks are entered just after a rising clock edge
// Notes:   Released index and data show the inverse of the last value
`timescale 1ns/10ps
module cmon_master_model
  import cmon_pkg::*;
(
  input  wire logic [15:0] param_rdata,
  input  wire logic        clk,
  input  wire logic        param_rvalid,
  input  wire logic        param_rerr,
  input  wire logic        param_wack,
  input  wire logic        param_werr,
  output logic             param_rd,
  output logic             param_wr,
  output logic [15:0]      param_index,
  output logic [15:0]      param_wdata
);
  initial begin
    {param_rd, param_wr, param_index, param_wdata} = '0;
  end

  // ****************************************************************
  // One strobe cycle, answer taken at the following edge
  // ****************************************************************
  task automatic rd(input logic [15:0] idx, output logic [15:0] d,
                    output logic e);
    param_rd    <= 1'b1;
    param_index <= idx;
    @(posedge clk);
    param_rd    <= 1'b0;
    param_index <= ~idx;
    @(posedge clk);
    d = param_rdata;
    e = param_rerr | ~param_rvalid;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] w,
                    output logic e);
    param_wr    <= 1'b1;
    param_index <= idx;
    param_wdata <= w;
    @(posedge clk);
    param_wr    <= 1'b0;
    param_index <= ~idx;
    param_wdata <= ~w;
    @(posedge clk);
    e = param_werr | ~param_wack;
  endtask
endmodule // cmon_master_model

// *** verif/cmon_monitor_chk.sv ***
// Purpose: Port-level checks of the condition monitor
// Assumes: Bound to cmon_monitor
// Notes:   Result indication is judged two samples after cycle end
`timescale 1ns/10ps
module cmon_monitor_chk
  import cmon_pkg::*;
#(
  parameter int TICK_CYC = 10
) (
  input logic        clk,
  input logic        rst_n,
  input logic        suction_cmd,
  input logic        has_pressure_sensor,
  input logic        iolink_mode,
  input logic        diag_output,
  input logic        suction_valve,
  input cmon_led_e   led_mode,
  input logic [7:0]  pd_in_byte,
  input logic [7:0]  condition_monitoring_flags
);
  logic       cmd_q;
  logic [7:0] fl;
  assign fl = condition_monitoring_flags;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cmd_q <= 1'b0;
    else cmd_q <= suction_cmd;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ended;
    !suction_cmd [*2];
  endsequence

  chk_pd_event: assert property (
    pd_in_byte[6] == (|fl)) else $error("event bit differs");
  chk_start_clear: assert property (
    suction_cmd && !cmd_q |=> !diag_output && fl[3:0] == 4'h0)
    else $error("start did not clear");
  chk_diag_hold: assert property (
    diag_output && !(suction_cmd && !cmd_q) |=> diag_output)
    else $error("diag dropped early");
  chk_diag_cause: assert property (
    $rose(diag_output) |-> fl[3:0] != 4'h0) else $error("diag cause");
  chk_iolink_only: assert property (
    $rose(fl[3]) |-> $past(iolink_mode)) else $error("flag off mode");
  chk_sensor_only: assert property (
    $rose(fl[7]) || $rose(fl[4]) |-> $past(has_pressure_sensor))
    else $error("pressure flag without sensor");
  chk_freq_cont: assert property (
    $rose(fl[0]) |-> ##[0:2] (suction_valve || !suction_cmd) [*4])
    else $error("no continuous suction");
  chk_red_result: assert property (
    s_ended ##0 (fl[3] && !fl[0] && !fl[2]) |-> led_mode == CMON_LED_RED_FLASH)
    else $error("red result missing");
  chk_grn_result: assert property (
    s_ended ##0 (fl[0] || fl[2]) |-> led_mode == CMON_LED_GRN_FLASH)
    else $error("green result missing");
  chk_leak_diag: assert property (
    $rose(fl[2]) |-> diag_output) else $error("leak without diag");
endmodule // cmon_monitor_chk

// *** verif/vacuum_condition_monitor_tb.sv ***
// Purpose: Self-checking bench of the condition monitor
// Assumes: One clock, TICK_CYC shortened to 10 cycles per ms
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/10ps
`include "cmon_defines.svh"
module vacuum_condition_monitor_tb
  import cmon_pkg::*;
;
  logic clk, rst_n, suction_cmd, has_pressure_sensor, iolink_mode;
  logic menu_factory_reset, param_rd, param_wr, param_rvalid, param_rerr;
  logic param_wack, param_werr, suction_valve, diag_output, e;
  logic [9:0]  vacuum;
  logic [7:0]  supply_pressure, pd_in_byte, condition_monitoring_flags;
  logic [15:0] param_index, param_wdata, param_rdata, d;
  logic [15:0] seed = 16'hC5E3;
  cmon_led_e   led_mode;
  int          n_errors, n_compared;

  cmon_monitor #(.TICK_CYC(10)) i_cmon_monitor (.*);
  cmon_master_model i_cmon_master_model (.*);

  always #5 clk = ~clk;

  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction

  function automatic logic [7:0] f_exp(logic fq, logic lk, logic ct,
                                        logic pr);
    return {pr, 3'h0, ct, lk, 1'b0, fq};
  endfunction

  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    n_compared++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic chk_flags(input logic [7:0] ex);
    i_cmon_master_model.rd(`CMON_IDX_FLAGS, d, e);
    chk("flags", {8'h0, ex}, d);
    chk("event bit", {15'h0, |ex}, {15'h0, pd_in_byte[6]});
  endtask

  task automatic outs(input logic dg, input logic vl, input cmon_led_e ld);
    chk("diag", {15'h0, dg}, {15'h0, diag_output});
    chk("valve", {15'h0, vl}, {15'h0, suction_valve});
    chk("led", {14'h0, ld}, {14'h0, led_mode});
  endtask

  task automatic hold(input logic [9:0] v, input int n);
    vacuum <= v;
    repeat (n) @(posedge clk);
  endtask

  task automatic test_done();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #300000;
    n_errors++;
    test_done();
  end

  initial begin
    {clk, rst_n, suction_cmd, has_pressure_sensor} = '0;
    {menu_factory_reset, vacuum} = '0;
    iolink_mode = 1'b1;
    supply_pressure = 8'h37;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    supply_pressure <= 8'(`CMON_DEF_PMIN + rnd() % 16'h1F);
    chk_flags(8'h00);
    for (int s = 0; s < 8; s++) begin
      i_cmon_master_model.wr(`CMON_IDX_LEAK, 16'(s), e);
      chk("leak refused", {15'h0, s > 6}, {15'h0, e});
    end
    i_cmon_master_model.wr(`CMON_IDX_EVAC, 16'h03E8, e);
    chk("evac 1000", 16'h1, {15'h0, e});
    i_cmon_master_model.wr(`CMON_IDX_EVAC, 16'h03E7, e);
    chk("evac 999", 16'h0, {15'h0, e});
    i_cmon_master_model.rd(16'h0000, d, e);
    chk("unmapped", 16'h1, {15'h0, e});
    i_cmon_master_model.wr(`CMON_IDX_H1, 16'h0258, e);
    i_cmon_master_model.wr(`CMON_IDX_EVAC, 16'h0001, e);
    suction_cmd <= 1'b1;
    hold(10'h226 + 10'(rnd() % 16'h32), 200);
    suction_cmd <= 1'b0;
    hold(vacuum, 3);
    chk_flags(8'h0A);
    outs(1'b1, 1'b0, CMON_LED_RED_FLASH);
    menu_factory_reset <= 1'b1;
    @(posedge clk);
    menu_factory_reset <= 1'b0;
    chk_flags(8'h0A);
    i_cmon_master_model.rd(`CMON_IDX_H1, d, e);
    chk("h1 default", {6'h0, `CMON_DEF_H1}, d);
    suction_cmd <= 1'b1;
    hold(10'h190, 20);
    chk_flags(8'h00);
    for (int i = 0; i < 10; i++) hold(i % 2 ? 10'h190 : 10'h320, 20);
    hold(10'h320, 30);
    chk_flags(f_exp(1, 0, 0, 0));
    outs(1'b1, 1'b1, CMON_LED_GRN_FLASH);
    suction_cmd <= 1'b0;
    hold(vacuum, 3);
    outs(1'b1, 1'b0, CMON_LED_GRN_FLASH);
    suction_cmd <= 1'b1;
    hold(10'h320, 300);
    hold(10'h2BC, 1500);
    outs(1'b0, 1'b1, CMON_LED_VACUUM);
    hold(10'h320, 300);
    hold(10'h2BC, 1500);
    chk_flags(f_exp(0, 1, 0, 0));
    outs(1'b1, 1'b1, CMON_LED_VACUUM);
    suction_cmd <= 1'b0;
    iolink_mode <= 1'b0;
    hold(10'(rnd() % 16'h1F4), 3);
    suction_cmd <= 1'b1;
    hold(vacuum, 100);
    suction_cmd <= 1'b0;
    hold(vacuum, 3);
    chk_flags(8'h00);
    iolink_mode <= 1'b1;
    supply_pressure <= 8'h10;
    hold(vacuum, 20);
    chk_flags(8'h00);
    has_pressure_sensor <= 1'b1;
    hold(vacuum, 20);
    chk_flags(f_exp(0, 0, 0, 1));
    outs(1'b0, 1'b0, CMON_LED_VACUUM);
    suction_cmd <= 1'b1;
    hold(10'h24E, 10050);
    chk_flags(8'h90);
    outs(1'b0, 1'b1, CMON_LED_VACUUM);
    test_done();
  end
endmodule // vacuum_condition_monitor_tb

bind cmon_monitor cmon_monitor_chk #(.TICK_CYC(TICK_CYC)) i_chk (.*);
